// [rtl/line_mode_pkg.sv]
package line_mode_pkg;

   // ---------------------------------------------------------------------
   // Register map (byte addresses on the AXI4-Lite slave)
   // ---------------------------------------------------------------------
   localparam logic [7:0] ctrl_addr       = 8'h00;
   localparam logic [7:0] status_addr     = 8'h04;
   localparam logic [7:0] irq_status_addr = 8'h08;
   localparam logic [7:0] irq_enable_addr = 8'h0c;
   localparam logic [7:0] irq_clear_addr  = 8'h10;

   // ---------------------------------------------------------------------
   // Control register fields
   // ---------------------------------------------------------------------
   localparam int ctrl_gain_bit   = 0;
   localparam int ctrl_extclk_bit = 1;
   localparam int ctrl_width      = 2;
   localparam logic [ctrl_width-1:0] ctrl_reset = 2'h0;

   // ---------------------------------------------------------------------
   // Status register fields
   // ---------------------------------------------------------------------
   localparam int st_mode_lsb   = 0;
   localparam int st_pol_bit    = 3;
   localparam int st_meter_bit  = 4;
   localparam int st_therm_bit  = 5;
   localparam int st_hook_bit   = 6;
   localparam int st_ac_bit     = 7;
   localparam int st_ring_v_bit = 8;
   localparam int st_width      = 9;

   // ---------------------------------------------------------------------
   // Interrupt event bits
   // ---------------------------------------------------------------------
   localparam int ev_mode_bit  = 0;
   localparam int ev_hook_bit  = 1;
   localparam int ev_therm_bit = 2;
   localparam int ev_width     = 3;
   localparam logic [ev_width-1:0] ev_reset = 3'h0;

   // ---------------------------------------------------------------------
   // AXI responses
   // ---------------------------------------------------------------------
   localparam logic [1:0] resp_okay   = 2'h0;
   localparam logic [1:0] resp_slverr = 2'h2;

   // ---------------------------------------------------------------------
   // Operating modes
   // ---------------------------------------------------------------------
   typedef enum logic [2:0] {
      mode_power_down = 3'b000,
      mode_hiz_feed   = 3'b001,
      mode_active     = 3'b010,
      mode_ringing    = 3'b011
   } op_mode_type;

endpackage : line_mode_pkg

// [rtl/line_interface_mode_control.sv]
// Function
// - Mode chosen from power pin and mode pins
// - Power on, pin a high, b low: ringing
// - Pin b high: active, metering, polarity
// - Metering active state for both polarities
// - Loop status output is active low
// - Loop status output is open drain
// - Hi-z feed: off-hook drives loop status low
// - Power down: line off, detectors disabled
// - Over temperature forces power down
// - Cooling below hysteresis restores previous mode
// - AC transmission only in active mode
// - Gain set selects receive/transmit gains
// - Converter uses external or internal clock
// - Ringing raises battery target to -70 V
// - Third pin sets direct or reverse polarity in active and ringing modes
`timescale 1ns/1ps
`default_nettype none

module line_interface_mode_control
   import line_mode_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        clk_en,
   input  wire logic        line_power_on_pin,
   input  wire logic        mode_pin_a,
   input  wire logic        mode_pin_b,
   input  wire logic        polarity_ring_pin,
   input  wire logic        off_hook_in,
   input  wire logic        over_temp_in,
   input  wire logic        metering_tone_clock,
   input  wire logic        conv_clk_ext,
   input  wire logic        conv_clk_int,
   input  wire logic        loop_status_n_i,
   output logic             loop_status_n_o,
   output logic             loop_status_n_oe,
   output logic             line_drive_en,
   output logic             reverse_polarity,
   output logic             metering_en,
   output logic             metering_tone,
   output logic             ac_tx_en,
   output logic             gain_high,
   output logic             ring_battery_high,
   output logic             conv_clk_sel_ext,
   output logic             conv_clk_out,
   output logic             irq,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);

   import line_mode_pkg::*;

   // --------------------------------------------------------------------
   // Pin synchronisers
   // --------------------------------------------------------------------
   // Pins change with no relation to aclk, so each takes two flops first.
   localparam int n_pins = 7;
   logic [n_pins-1:0] pin_raw;
   logic [n_pins-1:0] sync1_reg;
   logic [n_pins-1:0] sync2_reg;
   logic [n_pins-1:0] sync1_next;
   logic [n_pins-1:0] sync2_next;

   assign pin_raw = {metering_tone_clock, over_temp_in, off_hook_in,
                     polarity_ring_pin, mode_pin_b, mode_pin_a,
                     line_power_on_pin};

   // Synchroniser next values; only the second stage is read by logic.
   always_comb begin
      sync1_next = sync1_reg;
      sync2_next = sync2_reg;
      if (!aresetn) begin
         sync1_next = '0;
         sync2_next = '0;
      end else if (clk_en) begin
         sync1_next = pin_raw;
         sync2_next = sync1_reg;
      end
   end

   always_ff @(posedge aclk) begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
   end

   logic pwr_s, pa_s, pb_s, pol_s, hook_s, temp_s, tone_s;
   assign {tone_s, temp_s, hook_s, pol_s, pb_s, pa_s, pwr_s} = sync2_reg;

   // --------------------------------------------------------------------
   // Mode decode
   // --------------------------------------------------------------------
   op_mode_type sel_mode;
   op_mode_type mode;

   // Decode of the pin selection; the third pin never affects the mode.
   always_comb begin
      if (pb_s)
         sel_mode = mode_active;
      else if (!pwr_s)
         sel_mode = mode_power_down;
      else if (pa_s)
         sel_mode = mode_ringing;
      else
         sel_mode = mode_hiz_feed;
   end

   // Thermal overload overrides the pins; since the selection is never
   // stored, the pin mode returns as soon as the sensor clears.
   assign mode = temp_s ? mode_power_down : sel_mode;

   // --------------------------------------------------------------------
   // Control register and outputs
   // --------------------------------------------------------------------
   logic [ctrl_width-1:0] ctrl_reg;
   logic [ctrl_width-1:0] ctrl_next;
   logic [ev_width-1:0]   ev_status_reg, ev_status_next;
   logic [ev_width-1:0]   ev_enable_reg, ev_enable_next;
   op_mode_type           mode_reg, mode_next;
   logic                  hook_reg, hook_next;
   logic                  temp_reg, temp_next;
   logic                  det_active;
   logic [ev_width-1:0]   ev_pulse;

   // Detector only runs where the line is fed; power down silences it.
   assign det_active = hook_s && (mode != mode_power_down);
   assign loop_status_n_o  = 1'b0;
   assign loop_status_n_oe = det_active;

   // Output state registered from the decoded mode.
   logic line_drive_reg, rev_reg, met_reg, tone_reg, ac_reg, ring_reg;
   logic line_drive_nx, rev_nx, met_nx, tone_nx, ac_nx, ring_nx;

   always_comb begin
      line_drive_nx = line_drive_reg;
      rev_nx  = rev_reg;
      met_nx  = met_reg;
      tone_nx = tone_reg;
      ac_nx   = ac_reg;
      ring_nx = ring_reg;
      if (!aresetn) begin
         line_drive_nx = 1'b0;
         rev_nx  = 1'b0;
         met_nx  = 1'b0;
         tone_nx = 1'b0;
         ac_nx   = 1'b0;
         ring_nx = 1'b0;
      end else if (clk_en) begin
         line_drive_nx = (mode != mode_power_down);
         rev_nx  = (mode == mode_active || mode == mode_ringing)
                   && pol_s;
         met_nx  = (mode == mode_active) && pa_s;
         tone_nx = (mode == mode_active) && pa_s && tone_s;
         ac_nx   = (mode == mode_active);
         ring_nx = (mode == mode_ringing);
      end
   end

   always_ff @(posedge aclk) begin
      line_drive_reg <= line_drive_nx;
      rev_reg  <= rev_nx;
      met_reg  <= met_nx;
      tone_reg <= tone_nx;
      ac_reg   <= ac_nx;
      ring_reg <= ring_nx;
   end

   assign line_drive_en     = line_drive_reg;
   assign reverse_polarity  = rev_reg;
   assign metering_en       = met_reg;
   assign metering_tone     = tone_reg;
   assign ac_tx_en          = ac_reg;
   assign ring_battery_high = ring_reg;
   // Gain set only matters while active; elsewhere there is no AC path.
   assign gain_high = ac_reg && ctrl_reg[ctrl_gain_bit];
   // Clock mux is combinational: a glitch-free switch would need both
   // clocks running, which the internal oscillator cannot promise.
   assign conv_clk_sel_ext = ctrl_reg[ctrl_extclk_bit];
   assign conv_clk_out = ctrl_reg[ctrl_extclk_bit] ? conv_clk_ext
                                                   : conv_clk_int;

   // --------------------------------------------------------------------
   // Events and interrupt
   // --------------------------------------------------------------------
   assign ev_pulse[ev_mode_bit]  = (mode != mode_reg);
   assign ev_pulse[ev_hook_bit]  = (det_active != hook_reg);
   assign ev_pulse[ev_therm_bit] = (temp_s != temp_reg);
   assign irq = |(ev_status_reg & ev_enable_reg);

   // --------------------------------------------------------------------
   // AXI4-Lite slave
   // --------------------------------------------------------------------
   logic        aw_ok, wr_go, rd_go;
   logic        bvalid_reg, bvalid_next;
   logic [1:0]  bresp_reg, bresp_next;
   logic        rvalid_reg, rvalid_next;
   logic [1:0]  rresp_reg, rresp_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [31:0] status_word;

   // Address and data are taken together, so either order works.
   // Ready rises only when the edge really takes the request; a frozen
   // block must not signal a transfer that it would then drop.
   assign aw_ok = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
   assign wr_go = aw_ok && clk_en;
   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   assign s_axi_arready = !rvalid_reg && clk_en;
   assign rd_go = s_axi_arvalid && s_axi_arready;

   assign status_word = {23'h0, ring_reg, ac_reg, det_active, temp_s,
                         met_reg, rev_reg, mode};

   // Bus, control and event state.
   always_comb begin
      ctrl_next      = ctrl_reg;
      ev_status_next = ev_status_reg;
      ev_enable_next = ev_enable_reg;
      mode_next      = mode_reg;
      hook_next      = hook_reg;
      temp_next      = temp_reg;
      bvalid_next    = bvalid_reg;
      bresp_next     = bresp_reg;
      rvalid_next    = rvalid_reg;
      rresp_next     = rresp_reg;
      rdata_next     = rdata_reg;
      if (!aresetn) begin
         ctrl_next      = ctrl_reset;
         ev_status_next = ev_reset;
         ev_enable_next = ev_reset;
         mode_next      = mode_power_down;
         hook_next      = 1'b0;
         temp_next      = 1'b0;
         bvalid_next    = 1'b0;
         bresp_next     = resp_okay;
         rvalid_next    = 1'b0;
         rresp_next     = resp_okay;
         rdata_next     = 32'h0;
      end else if (clk_en) begin
         mode_next = mode;
         hook_next = det_active;
         temp_next = temp_s;
         if (bvalid_reg && s_axi_bready)
            bvalid_next = 1'b0;
         if (rvalid_reg && s_axi_rready)
            rvalid_next = 1'b0;
         if (wr_go) begin
            bvalid_next = 1'b1;
            bresp_next  = resp_okay;
            case (s_axi_awaddr)
               ctrl_addr:
                  if (s_axi_wstrb[0])
                     ctrl_next = s_axi_wdata[ctrl_width-1:0];
               irq_enable_addr:
                  if (s_axi_wstrb[0])
                     ev_enable_next = s_axi_wdata[ev_width-1:0];
               irq_clear_addr:
                  if (s_axi_wstrb[0])
                     ev_status_next = ev_status_reg
                                      & ~s_axi_wdata[ev_width-1:0];
               status_addr, irq_status_addr: ;
               default: bresp_next = resp_slverr;
            endcase
         end
         // New events win over a clear in the same cycle.
         ev_status_next = ev_status_next | ev_pulse;
         if (rd_go) begin
            rvalid_next = 1'b1;
            rresp_next  = resp_okay;
            case (s_axi_araddr)
               ctrl_addr:       rdata_next = {30'h0, ctrl_reg};
               status_addr:     rdata_next = status_word;
               irq_status_addr: rdata_next = {29'h0, ev_status_reg};
               irq_enable_addr: rdata_next = {29'h0, ev_enable_reg};
               irq_clear_addr:  rdata_next = 32'h0;
               default: begin
                  rdata_next = 32'h0;
                  rresp_next = resp_slverr;
               end
            endcase
         end
      end
   end

   always_ff @(posedge aclk) begin
      ctrl_reg      <= ctrl_next;
      ev_status_reg <= ev_status_next;
      ev_enable_reg <= ev_enable_next;
      mode_reg      <= mode_next;
      hook_reg      <= hook_next;
      temp_reg      <= temp_next;
      bvalid_reg    <= bvalid_next;
      bresp_reg     <= bresp_next;
      rvalid_reg    <= rvalid_next;
      rresp_reg     <= rresp_next;
      rdata_reg     <= rdata_next;
   end

   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp  = bresp_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp  = rresp_reg;
   assign s_axi_rdata  = rdata_reg;

endmodule : line_interface_mode_control

`default_nettype wire

// [bench/line_mode_checker_sva.sv]
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------------
// Mode decode checker
// ---------------------------------------------------------------------
module line_mode_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   input wire logic line_power_on_pin,
   input wire logic mode_pin_a,
   input wire logic mode_pin_b,
   input wire logic polarity_ring_pin,
   input wire logic off_hook_in,
   input wire logic over_temp_in,
   input wire logic conv_clk_ext,
   input wire logic conv_clk_int,
   input wire logic loop_status_n_o,
   input wire logic loop_status_n_oe,
   input wire logic line_drive_en,
   input wire logic reverse_polarity,
   input wire logic metering_en,
   input wire logic metering_tone_clock,
   input wire logic metering_tone,
   input wire logic ac_tx_en,
   input wire logic gain_high,
   input wire logic ring_battery_high,
   input wire logic conv_clk_sel_ext,
   input wire logic conv_clk_out
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Pins held long enough to clear both sync stages and the output flop.
   sequence steady;
      ($stable({clk_en, line_power_on_pin, mode_pin_a, mode_pin_b,
         polarity_ring_pin, off_hook_in, over_temp_in}) && clk_en)[*4];
   endsequence

   power_down_a: assert property (steady ##0 (!over_temp_in &&
      !line_power_on_pin && !mode_pin_a && !mode_pin_b) |->
      !line_drive_en && !loop_status_n_oe && !ac_tx_en)
      else $error("power down outputs wrong");
   hiz_feed_a: assert property (steady ##0 (!over_temp_in &&
      line_power_on_pin && !mode_pin_a && !mode_pin_b) |->
      loop_status_n_oe == off_hook_in && !ac_tx_en)
      else $error("high impedance feed outputs wrong");
   ringing_mode_a: assert property (steady ##0 (!over_temp_in &&
      line_power_on_pin && mode_pin_a && !mode_pin_b) |->
      ring_battery_high && !ac_tx_en) else $error("ringing outputs wrong");
   active_mode_a: assert property (steady ##0 (mode_pin_b &&
      !over_temp_in) |-> ac_tx_en && !ring_battery_high && metering_en ==
      mode_pin_a && reverse_polarity == polarity_ring_pin)
      else $error("active outputs wrong");
   thermal_off_a: assert property (steady ##0 over_temp_in |->
      !line_drive_en && !ac_tx_en && !loop_status_n_oe)
      else $error("over temperature did not power down");
   thermal_return_a: assert property (($fell(over_temp_in) &&
      mode_pin_b && clk_en) ##1
      ($stable({mode_pin_b, over_temp_in}) && clk_en)[*4]
      |-> ac_tx_en) else $error("mode not restored after cooling");
   // The tone passes two sync stages and one output flop: three edges.
   tone_follow_a: assert property (metering_en && $past(clk_en) &&
      $past(clk_en, 2) && $past(clk_en, 3) |->
      metering_tone == $past(metering_tone_clock, 3))
      else $error("metering tone not passed through");
   open_drain_a: assert property (!loop_status_n_o)
      else $error("loop status pin driven high");
   gain_set_a: assert property (gain_high |-> ac_tx_en)
      else $error("gain set outside active mode");
   conv_clock_a: assert property (conv_clk_out == (conv_clk_sel_ext ?
      conv_clk_ext : conv_clk_int)) else $error("converter clock source wrong");
endmodule : line_mode_checker

bind line_interface_mode_control line_mode_checker chk (.aclk, .aresetn,
   .clk_en, .line_power_on_pin, .mode_pin_a, .mode_pin_b, .polarity_ring_pin,
   .off_hook_in, .over_temp_in, .conv_clk_ext, .conv_clk_int,
   .loop_status_n_o, .loop_status_n_oe, .line_drive_en, .reverse_polarity,
   .metering_en, .metering_tone_clock, .metering_tone, .ac_tx_en,
   .gain_high, .ring_battery_high,
   .conv_clk_sel_ext, .conv_clk_out);

`default_nettype wire

// [bench/line_card_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------------
// Line card controller model
// ---------------------------------------------------------------------
module line_card_ctrl (
   input  wire logic aclk,
   input  wire logic [4:0] cmd,
   input  wire logic loop_wire,
   output logic      line_power_on_pin,
   output logic      mode_pin_a,
   output logic      mode_pin_b,
   output logic      polarity_ring_pin,
   output logic      metering_tone_clock,
   output logic      ring_tripped
);
   logic [1:0] loop_sync;
   logic [2:0] ring_cnt;

   // Start in power down so no pin is unknown before the first edge.
   initial begin
      {line_power_on_pin, mode_pin_a, mode_pin_b} = 3'h0;
      {polarity_ring_pin, metering_tone_clock, ring_tripped} = 3'h0;
      loop_sync = 2'h3;
      ring_cnt = 3'h0;
   end

   // The loop line is asynchronous, so it is resynchronised before use.
   always @(posedge aclk) begin
      loop_sync <= {loop_sync[0], loop_wire};
      ring_cnt <= ring_cnt + 3'h1;
      metering_tone_clock <= cmd[3] & ~metering_tone_clock;
      ring_tripped <= cmd[0] & (ring_tripped | ~loop_sync[1]);
      if (cmd[0] && !ring_tripped) begin
         {line_power_on_pin, mode_pin_a, mode_pin_b} <= 3'h6;
         if (ring_cnt == 3'h7) polarity_ring_pin <= ~polarity_ring_pin;
      end else if (ring_tripped) begin
         {line_power_on_pin, mode_pin_a, mode_pin_b} <= 3'h5;
         polarity_ring_pin <= 1'b0;
      end else begin
         {line_power_on_pin, mode_pin_a, mode_pin_b} <= cmd[4:2];
         polarity_ring_pin <= cmd[1];
      end
   end
endmodule : line_card_ctrl

`default_nettype wire

// [bench/line_interface_mode_control_test.sv]
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------------
// Top level bench
// ---------------------------------------------------------------------
module line_interface_mode_control_test;
   import line_mode_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0, off_hook_in = 1'b0;
   logic over_temp_in = 1'b0, conv_clk_ext = 1'b0, clk_en = 1'b1;
   logic [4:0] cmd = 5'h0;
   logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic line_power_on_pin, mode_pin_a, mode_pin_b, polarity_ring_pin;
   logic metering_tone_clock, ring_tripped, loop_status_n_o;
   logic loop_status_n_oe, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic ac_tx_en, gain_high, ring_battery_high, conv_clk_out, irq;
   logic s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   int mismatches = 0;
   int samples_checked = 0;
   // Pull-up on the open-drain loop status line.
   wire loop_wire = loop_status_n_oe ? loop_status_n_o : 1'b1;

   always #4 aclk = ~aclk;
   // Toggling the external source shows which converter clock is passed.
   always @(posedge aclk) conv_clk_ext <= ~conv_clk_ext;

   line_interface_mode_control dut (.aclk, .aresetn, .clk_en,
      .line_power_on_pin, .mode_pin_a, .mode_pin_b, .polarity_ring_pin,
      .off_hook_in, .over_temp_in, .metering_tone_clock, .conv_clk_ext,
      .conv_clk_int(1'b0), .loop_status_n_i(loop_wire), .loop_status_n_o,
      .loop_status_n_oe, .line_drive_en(), .reverse_polarity(),
      .metering_en(), .metering_tone(), .ac_tx_en, .gain_high,
      .ring_battery_high, .conv_clk_sel_ext(), .conv_clk_out, .irq,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready(1'b1));

   line_card_ctrl ctrl (.aclk, .cmd, .loop_wire, .line_power_on_pin,
      .mode_pin_a, .mode_pin_b, .polarity_ring_pin, .metering_tone_clock,
      .ring_tripped);

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic settle;
      repeat (5) @(posedge aclk);
   endtask : settle

   // Ready is sampled at each edge; the answer ends the wait.
   task automatic axi_wr(input logic [7:0] ad, input logic [31:0] dt,
                         output logic [1:0] r);
      s_axi_awaddr <= ad;
      s_axi_wdata <= dt;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] ad, output logic [31:0] d,
                         output logic [1:0] r);
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask : axi_rd

   // Command bits are power, pin a, pin b, polarity and ring request.
   task automatic st_check(input logic [4:0] c);
      logic [31:0] d;
      logic [1:0] r;
      logic [2:0] m;
      m = over_temp_in ? 3'h0 : c[2] ? 3'h2 : c[4] && c[3] ? 3'h3 :
          c[4] ? 3'h1 : 3'h0;
      axi_rd(status_addr, d, r);
      check(d, {23'h0, m == 3'h3, m == 3'h2, off_hook_in && m != 3'h0,
         over_temp_in, m == 3'h2 && c[3], m[1] && c[1], m});
      check(loop_wire, !(off_hook_in && m != 3'h0));
   endtask : st_check

   task automatic t_regs;
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(ctrl_addr, d, r);
      check(d, 32'h0);
      cmd <= 5'h14;
      settle();
      check(gain_high, 1'b0);
      check(conv_clk_out, 1'b0);
      axi_wr(ctrl_addr, 32'h3, r);
      check(gain_high, 1'b1);
      check(conv_clk_out, conv_clk_ext);
      @(posedge aclk);
      check(conv_clk_out, conv_clk_ext);
      axi_wr(status_addr, 32'h1ff, r);
      check(r, resp_okay);
      st_check(5'h14);
      axi_rd(8'h14, d, r);
      check(r, resp_slverr);
      axi_wr(ctrl_addr, 32'h0, r);
   endtask : t_regs

   // Every row of the mode table with the power pin high, then power down.
   task automatic t_modes;
      for (int i = 0; i < 8; i++) begin
         cmd <= {1'b1, i[2:0], 1'b0};
         settle();
         st_check({1'b1, i[2:0], 1'b0});
      end
      cmd <= 5'h0;
      settle();
      st_check(5'h0);
   endtask : t_modes

   task automatic t_hook;
      logic [31:0] d;
      logic [1:0] r;
      cmd <= 5'h10;
      settle();
      axi_wr(irq_clear_addr, 32'h7, r);
      axi_wr(irq_enable_addr, 32'h2, r);
      check(irq, 1'b0);
      off_hook_in <= 1'b1;
      settle();
      st_check(5'h10);
      check(irq, 1'b1);
      axi_wr(irq_enable_addr, 32'h0, r);
      check(irq, 1'b0);
      axi_rd(irq_status_addr, d, r);
      check(d, 32'h2);
      axi_wr(irq_clear_addr, 32'h2, r);
      axi_rd(irq_status_addr, d, r);
      check(d, 32'h0);
      cmd <= 5'h0;
      settle();
      st_check(5'h0);
      off_hook_in <= 1'b0;
   endtask : t_hook

   // Heat in active metering with reverse polarity, then cool down.
   task automatic t_therm;
      cmd <= 5'h1e;
      off_hook_in <= 1'b1;
      over_temp_in <= 1'b1;
      settle();
      st_check(5'h1e);
      over_temp_in <= 1'b0;
      settle();
      st_check(5'h1e);
      off_hook_in <= 1'b0;
   endtask : t_therm

   // Ringing until the handset lifts; the controller then selects active.
   task automatic t_ring;
      int n = 0;
      // The loop line must read on-hook again before ringing starts, or
      // the controller would take the old off-hook for a ring trip.
      settle();
      cmd <= 5'h01;
      settle();
      settle();
      check(ring_battery_high, 1'b1);
      off_hook_in <= 1'b1;
      while (!ring_tripped && n < 50) begin
         @(posedge aclk);
         n++;
      end
      check(ring_tripped, 1'b1);
      settle();
      st_check(5'h14);
      cmd <= 5'h0;
      off_hook_in <= 1'b0;
      settle();
   endtask : t_ring

   // Clock enable low must hold the old mode until it rises again.
   task automatic t_freeze;
      clk_en <= 1'b0;
      cmd <= 5'h14;
      settle();
      check(ac_tx_en, 1'b0);
      clk_en <= 1'b1;
      settle();
      check(ac_tx_en, 1'b1);
   endtask : t_freeze

   task automatic finish_test;
      $display("checked %0d, mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : finish_test

   // The full run is well under a thousand cycles.
   initial begin
      #(5000 * 8);
      mismatches++;
      finish_test();
   end

   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_modes();
      t_hook();
      t_therm();
      t_ring();
      t_freeze();
      finish_test();
   end
endmodule : line_interface_mode_control_test

`default_nettype wire
